// >>> csc_pkg.sv
package csc_pkg;

  localparam logic [7:0] ADDR_DETAILS_TWO = 8'h15;
  localparam logic [7:0] ADDR_CONFIG_ZERO = 8'h16;

  localparam int BIT_HOST_SEL = 7;
  localparam int BIT_CTRL_LSB = 4;
  localparam int BIT_ZONE_LSB = 4;
  localparam int BIT_FREQ_LSB = 1;
  localparam int BIT_CELL = 0;

  localparam logic HOST_SEL_RESET = 1'h0;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [3:0] MODE_RESET = 4'h5;
  localparam logic [2:0] ZONE_RESET = 3'h2;
  localparam logic [1:0] FREQ_RESET = 2'h0;
  localparam logic CELL_RESET = 1'h0;

  localparam logic [3:0] STATE_PIN_MISMATCH = 4'h5;
  localparam logic [3:0] STATE_THERMAL = 4'hC;
  localparam logic [3:0] STATE_BATT_REMOVED = 4'hD;
  localparam logic [3:0] STATE_OFF = 4'h8;

  localparam logic [3:0] MODE_DCDC_ONLY = 4'h4;
  localparam logic [3:0] MODE_CHARGE_LO = 4'h5;
  localparam logic [3:0] MODE_CHARGE_HI = 4'h7;

  localparam logic [3:0] PINS_ALL_VALID = 4'hF;
  localparam logic [3:0] PINS_NONE_VALID = 4'h0;

  localparam int SYNC_W = 10;

  typedef enum logic [2:0] {
    CSC_ZONE_COLD = 3'h0,
    CSC_ZONE_COOL = 3'h1,
    CSC_ZONE_NORMAL = 3'h2,
    CSC_ZONE_WARM = 3'h3,
    CSC_ZONE_HOT = 3'h4,
    CSC_ZONE_REMOVED = 3'h5,
    CSC_ZONE_OFF = 3'h6,
    CSC_ZONE_RSVD = 3'h7
  } csc_zone_t;

  // Pin-side inputs, all asynchronous to clk
  typedef struct packed {
    logic [2:0] thermal_zone;
    logic [1:0] switch_freq;
    logic cell_count;
    logic [3:0] pin_valid;
  } csc_pins_t;

  typedef struct packed {
    logic [7:0] input_current_limit;
    logic [7:0] charge_current_setting;
    logic [7:0] charge_voltage_setting;
    logic [7:0] topoff_current_threshold;
  } csc_settings_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csc_bus_req_t;

endpackage

// >>> csc_sync.sv
`timescale 1ns/1ps
module csc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] reset_val,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage_reg;

  // One double-flop per bit; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          // Both stages start at the documented idle levels, so no false status after reset
          stage_reg[i] <= reset_val[i];
          sync_out[i] <= reset_val[i];
        end
        else
        begin
          stage_reg[i] <= async_in[i];
          sync_out[i] <= stage_reg[i];
        end
      end
    end
  endgenerate

endmodule

// >>> csc_regs.sv
`timescale 1ns/1ps
module csc_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire csc_pkg::csc_bus_req_t bus_req,
  input wire csc_pkg::csc_pins_t pins,
  input wire csc_pkg::csc_settings_t pin_settings,
  input wire csc_pkg::csc_settings_t host_settings,
  input wire logic [3:0] core_state,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output csc_pkg::csc_settings_t active_settings,
  output logic [3:0] charger_state_report,
  output logic charge_suspend,
  output logic charger_enable,
  output logic dcdc_enable,
  output logic host_config_select,
  output logic battery_switch_force_off,
  output logic input_standby_select,
  output logic watchdog_timer_enable
);

  typedef struct packed {
    logic host_sel;
    logic [2:0] ctrl;
    logic [3:0] mode;
    logic [7:0] rdata;
    logic rvalid;
    csc_pkg::csc_settings_t settings;
    logic [3:0] state;
    logic suspend;
    logic chg_en;
    logic dcdc_en;
  } csc_state_t;

  csc_state_t state_reg;
  csc_state_t state_next;
  csc_pkg::csc_pins_t pins_sync;
  logic [7:0] status_word;
  logic partial_pins;
  logic thermal_limit;

  // Pins are analog-side levels, so double-flop before use
  csc_sync #(
    .W(csc_pkg::SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(pins),
    .reset_val({csc_pkg::ZONE_RESET, csc_pkg::FREQ_RESET, csc_pkg::CELL_RESET,
      csc_pkg::PINS_ALL_VALID}),
    .sync_out(pins_sync)
  );

  always_comb
  begin
    status_word = 8'h00;
    status_word[csc_pkg::BIT_ZONE_LSB +: 3] = pins_sync.thermal_zone;
    status_word[csc_pkg::BIT_FREQ_LSB +: 2] = pins_sync.switch_freq;
    status_word[csc_pkg::BIT_CELL] = pins_sync.cell_count;
  end

  // Mismatch only when some, not all, pins are valid
  assign partial_pins = (pins_sync.pin_valid != csc_pkg::PINS_ALL_VALID) &&
    (pins_sync.pin_valid != csc_pkg::PINS_NONE_VALID);
  assign thermal_limit = (pins_sync.thermal_zone == csc_pkg::CSC_ZONE_COLD) ||
    (pins_sync.thermal_zone == csc_pkg::CSC_ZONE_COOL) ||
    (pins_sync.thermal_zone == csc_pkg::CSC_ZONE_WARM) ||
    (pins_sync.thermal_zone == csc_pkg::CSC_ZONE_HOT);

  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    if (bus_req.wr && bus_req.addr == csc_pkg::ADDR_CONFIG_ZERO)
    begin
      // Sticky: a zero write cannot leave host mode
      if (bus_req.wdata[csc_pkg::BIT_HOST_SEL])
      begin
        state_next.host_sel = 1'b1;
      end
      state_next.ctrl = bus_req.wdata[csc_pkg::BIT_CTRL_LSB +: 3];
      state_next.mode = bus_req.wdata[3:0];
    end
    if (bus_req.rd)
    begin
      state_next.rvalid = 1'b1;
      unique case (bus_req.addr)
        csc_pkg::ADDR_DETAILS_TWO: state_next.rdata = status_word;
        csc_pkg::ADDR_CONFIG_ZERO: state_next.rdata = {state_reg.host_sel, state_reg.ctrl,
          state_reg.mode};
        default: state_next.rdata = 8'h00;
      endcase
    end
    state_next.settings = state_reg.host_sel ? host_settings : pin_settings;
    state_next.suspend = partial_pins && !state_reg.host_sel;
    // Pin mismatch outranks thermal codes; only the mismatch sets charge_suspend
    if (state_next.suspend)
    begin
      state_next.state = csc_pkg::STATE_PIN_MISMATCH;
    end
    else if (thermal_limit)
    begin
      state_next.state = csc_pkg::STATE_THERMAL;
    end
    else if (pins_sync.thermal_zone == csc_pkg::CSC_ZONE_REMOVED)
    begin
      state_next.state = csc_pkg::STATE_BATT_REMOVED;
    end
    else if (!state_reg.chg_en)
    begin
      state_next.state = csc_pkg::STATE_OFF;
    end
    else
    begin
      state_next.state = core_state;
    end
    state_next.chg_en = (state_reg.mode >= csc_pkg::MODE_CHARGE_LO) &&
      (state_reg.mode <= csc_pkg::MODE_CHARGE_HI);
    state_next.dcdc_en = (state_reg.mode >= csc_pkg::MODE_DCDC_ONLY) &&
      (state_reg.mode <= csc_pkg::MODE_CHARGE_HI);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.host_sel <= csc_pkg::HOST_SEL_RESET;
      state_reg.ctrl <= csc_pkg::CTRL_RESET;
      state_reg.mode <= csc_pkg::MODE_RESET;
      state_reg.state <= csc_pkg::STATE_OFF;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign reg_rvalid = state_reg.rvalid;
  assign active_settings = state_reg.settings;
  assign charger_state_report = state_reg.state;
  assign charge_suspend = state_reg.suspend;
  assign charger_enable = state_reg.chg_en;
  assign dcdc_enable = state_reg.dcdc_en;
  assign host_config_select = state_reg.host_sel;
  assign battery_switch_force_off = state_reg.ctrl[2];
  assign input_standby_select = state_reg.ctrl[1];
  assign watchdog_timer_enable = state_reg.ctrl[0];

  a_status_zone: assert property (@(posedge clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == csc_pkg::ADDR_DETAILS_TWO |=>
    reg_rdata[6:4] == $past(pins_sync.thermal_zone))
    else $error("zone field wrong");
  a_thermal_state: assert property (@(posedge clk) disable iff (!rst_n)
    thermal_limit && !partial_pins |=> charger_state_report == csc_pkg::STATE_THERMAL)
    else $error("thermal state code missing");
  a_status_freq: assert property (@(posedge clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == csc_pkg::ADDR_DETAILS_TWO |=>
    reg_rdata[2:1] == $past(pins_sync.switch_freq))
    else $error("freq field wrong");
  a_status_cell: assert property (@(posedge clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == csc_pkg::ADDR_DETAILS_TWO |=>
    reg_rdata[0] == $past(pins_sync.cell_count))
    else $error("cell field wrong");
  a_pin_settings: assert property (@(posedge clk) disable iff (!rst_n)
    !host_config_select |=> active_settings == $past(pin_settings))
    else $error("pin settings not used");
  a_host_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    host_config_select |=> host_config_select)
    else $error("host select dropped");
  a_host_set: assert property (@(posedge clk) disable iff (!rst_n)
    bus_req.wr && bus_req.addr == csc_pkg::ADDR_CONFIG_ZERO && bus_req.wdata[7]
    |=> host_config_select ##1 active_settings == $past(host_settings))
    else $error("host select not taken");
  a_suspend_clear: assert property (@(posedge clk) disable iff (!rst_n)
    host_config_select |=> !charge_suspend)
    else $error("suspension survives host mode");
  a_mismatch_code: assert property (@(posedge clk) disable iff (!rst_n)
    partial_pins && !host_config_select |=>
    charger_state_report == csc_pkg::STATE_PIN_MISMATCH)
    else $error("mismatch code missing");
  a_mode_decode: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg.mode == csc_pkg::MODE_RESET && $stable(state_reg.mode) |=>
    charger_enable && dcdc_enable)
    else $error("mode 5 does not enable");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == csc_pkg::ADDR_DETAILS_TWO |=>
    reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
    else $error("reserved status bits set");

endmodule

// >>> csc_host_model.sv
`timescale 1ns/1ps
module csc_host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output csc_pkg::csc_bus_req_t bus_req
);
  initial bus_req = '0;
  // One byte per access; unanswered read gives X so it never matches
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge clk);
    bus_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    bus_req = '0;
    q = reg_rvalid ? reg_rdata : 8'hXX;
  endtask
endmodule

// >>> tb_charger_status_config_regs.sv
`timescale 1ns/1ps
module tb_charger_status_config_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  csc_pkg::csc_bus_req_t bus_req;
  csc_pkg::csc_pins_t pins;
  csc_pkg::csc_settings_t pin_settings, host_settings, active_settings;
  logic [3:0] core_state, charger_state_report;
  logic [7:0] reg_rdata, q;
  wire [2:0] ctl;
  logic reg_rvalid, charge_suspend, charger_enable, dcdc_enable, host_config_select;
  logic [31:0] r = 32'h0B8E7CDB;
  int failures = 0;
  int checked = 0;
  int z, f, c, v;
  always #12.5 clk = ~clk;
  csc_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .bus_req(bus_req));
  csc_regs DUT (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .pins(pins),
    .pin_settings(pin_settings), .host_settings(host_settings), .core_state(core_state),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .active_settings(active_settings),
    .charger_state_report(charger_state_report), .charge_suspend(charge_suspend),
    .charger_enable(charger_enable), .dcdc_enable(dcdc_enable),
    .host_config_select(host_config_select), .battery_switch_force_off(ctl[2]),
    .input_standby_select(ctl[1]), .watchdog_timer_enable(ctl[0]));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Priority order of the state report
  function automatic int m_state(int sel, int en);
    if (!sel && v != 0 && v != 15)
      return 5;
    if (z < 5 && z != 2)
      return 12;
    if (z == 5)
      return 13;
    if (!en)
      return 8;
    return core_state;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Pins pass two sync flops and a register, so allow four edges
  task automatic pinset;
    @(negedge clk);
    pins = '{thermal_zone: 3'(z), switch_freq: 2'(f), cell_count: 1'(c), pin_valid: 4'(v)};
    repeat (4) @(negedge clk);
  endtask
  task automatic results;
    $display("Checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #500us;
    failures++;
    results();
  end
  initial
  begin
    pins = '0;
    pin_settings = 32'h11223344;
    host_settings = 32'hA1B2C3D4;
    core_state = 4'h1;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    z = 2;
    f = 0;
    c = 0;
    v = 15;
    pinset();
    host.access(1'b0, 8'h16, 8'h00, q);
    chk("config", 8'h05, q);
    chk("enables", 2'b11, {charger_enable, dcdc_enable});
    chk("host_sel", 1'b0, host_config_select);
    chk("active", pin_settings, active_settings);
    for (int i = 0; i < 16; i++)
    begin
      r = xs(r);
      z = i % 8;
      f = r[1:0];
      c = r[2];
      v = r[3] ? 15 : 0;
      core_state = r[7:4];
      pinset();
      host.access(1'b0, 8'h15, 8'h00, q);
      chk("status", z * 16 + f * 2 + c, q);
      chk("state", m_state(0, 1), charger_state_report);
    end
    host.access(1'b1, 8'h15, 8'hFF, q);
    host.access(1'b0, 8'h15, 8'h00, q);
    chk("status_wr", z * 16 + f * 2 + c, q);
    host.access(1'b0, 8'h40, 8'h00, q);
    chk("unmapped", 8'h00, q);
    z = 2;
    v = 3;
    pinset();
    chk("state", 4'h5, charger_state_report);
    chk("suspend", 1'b1, charge_suspend);
    host.access(1'b1, 8'h16, 8'h05, q);
    repeat (2) @(negedge clk);
    chk("host_sel", 1'b0, host_config_select);
    chk("state", 4'h5, charger_state_report);
    chk("active", pin_settings, active_settings);
    host.access(1'b1, 8'h16, 8'h85, q);
    repeat (2) @(negedge clk);
    chk("host_sel", 1'b1, host_config_select);
    chk("suspend", 1'b0, charge_suspend);
    chk("state", m_state(1, 1), charger_state_report);
    chk("active", host_settings, active_settings);
    r = xs(r);
    host_settings = r;
    repeat (2) @(negedge clk);
    chk("active", host_settings, active_settings);
    host.access(1'b1, 8'h16, 8'h70, q);
    repeat (3) @(negedge clk);
    host.access(1'b0, 8'h16, 8'h00, q);
    chk("config", 8'hF0, q);
    chk("ctl", 3'b111, ctl);
    chk("state", m_state(1, 0), charger_state_report);
    chk("enables", 2'b00, {charger_enable, dcdc_enable});
    host.access(1'b1, 8'h16, 8'h84, q);
    repeat (3) @(negedge clk);
    chk("enables", 2'b01, {charger_enable, dcdc_enable});
    chk("ctl", 3'b000, ctl);
    chk("host_sel", 1'b1, host_config_select);
    results();
  end
endmodule
